// ===== hdl/smwl_pkg.sv
// constants, state codes and command layout for the spi master block
// assumes one 10 mhz clock; used by the master, which sizes its command fifo from it
package smwl_pkg;

  // clock and serial clock timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SCLK_HALF_NS = 1000;
  // least time, so round the half period up to whole cycles
  localparam int unsigned SCLK_HALF_CYC =
    (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // transfer length
  localparam int unsigned MAX_BITS = 24;
  localparam int unsigned LEN_W = 5;
  localparam logic [4:0] LEN_MIN = 5'h01;
  localparam logic [4:0] LEN_MAX = 5'h18;

  // execute control field positions
  localparam int unsigned EXE_GO_BIT = 0;
  localparam int unsigned EXE_SS_BIT = 1;

  // queued command layout: ss, go, cpha, length, transmit word
  localparam int unsigned CMD_W = 32;
  localparam int unsigned CMD_SS_POS = 31;
  localparam int unsigned CMD_GO_POS = 30;
  localparam int unsigned CMD_CPHA_POS = 29;
  localparam int unsigned CMD_LEN_POS = 24;
  localparam int unsigned CMD_FIFO_DEPTH = 4;

  // reset values
  localparam logic SS_LEVEL_RST = 1'b1;
  localparam logic [15:0] DIV_RST = 16'h0000;
  localparam logic [5:0] EDGE_RST = 6'h00;
  localparam logic [23:0] WORD_RST = 24'h000000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // transfer engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_TAIL = 3'b100
  } smwl_state_e;

endpackage : smwl_pkg

// ===== hdl/smwl_fifo.sv
// small synchronous fifo that queues execute commands for the master
// assumes a power of two depth; single clock, synchronous active high reset
`timescale 1ns/1ps

module smwl_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  logic in_ready_r;
  logic out_valid_r;
  wire push = in_valid & in_ready_r;
  wire pop = out_valid_r & out_ready;

  // flags are registered from the next count so the ports come off flops
  assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready = in_ready_r;
  assign out_valid = out_valid_r;
  assign out_data = mem[rd_ptr_r];

  // storage needs no reset; valid flags guard every read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      in_ready_r <= 1'b0;
      out_valid_r <= 1'b0;
    end else begin
      wr_ptr_r <= push ? AW'(wr_ptr_r + 1'b1) : wr_ptr_r;
      rd_ptr_r <= pop ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;
      count_r <= count_nxt;
      in_ready_r <= count_nxt != (AW+1)'(DEPTH);
      out_valid_r <= count_nxt != '0;
    end
  end

endmodule : smwl_fifo

// ===== hdl/smwl_spi_master.sv
// serial peripheral master with internal loopback
// assumes a 10 mhz clock, synchronous reset, configuration from plain ports
//
// Notes on behaviour
// - pin enable maps pins four-seven to master
// - drive clock, data out, select; data in
// - polarity bit inverts the serial clock
// - phase bit picks leading or trailing sample
// - shift one to twenty-four programmed bits
// - three transmit bytes, first is least significant
// - execute 0x01 selects slave and starts
// - execute 0x02 deselects, no transfer
// - received bits land in three receive bytes
// - loopback feeds transmit data into receive path
// - loopback leaves all pin levels static
// - loopback receive bytes equal transmit bytes in the programmed low bits, upper bits zero
// - select held at level when loopback entered
// - loopback takes writes like normal transfer
`timescale 1ns/1ps

module smwl_spi_master #(
  parameter int unsigned HALF_CYC = smwl_pkg::SCLK_HALF_CYC,
  parameter int unsigned FIFO_DEPTH = smwl_pkg::CMD_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin_config_first,
  input wire logic cfg_cpol,
  input wire logic cfg_cpha,
  input wire logic [4:0] transfer_length_field,
  input wire logic [7:0] transmit_byte_low,
  input wire logic [7:0] transmit_byte_mid,
  input wire logic [7:0] transmit_byte_high,
  input wire logic execute_wr,
  input wire logic [7:0] execute_control,
  input wire logic loopback_en,
  output logic execute_ready,
  output logic port_pin_four_o,
  output logic port_pin_four_oe,
  output logic port_pin_five_o,
  output logic port_pin_five_oe,
  input wire logic port_pin_six_i,
  output logic port_pin_seven_o,
  output logic port_pin_seven_oe,
  output logic [7:0] receive_byte_low,
  output logic [7:0] receive_byte_mid,
  output logic [7:0] receive_byte_high,
  output logic xfer_busy,
  output logic xfer_done,
  output logic ss_level
);
  import smwl_pkg::*;

  // data in reaches the sampler one pin flop and two sync flops after the
  // slave's edge, so a half period below four cycles reads stale bits
  localparam logic [15:0] HALF_LAST = 16'(HALF_CYC - 1);

  // clamp the length field into the supported range
  function automatic logic [4:0] len_clamp(input logic [4:0] len);
    logic [4:0] r;
    r = len;
    if (len < LEN_MIN) begin
      r = LEN_MIN;
    end else if (len > LEN_MAX) begin
      r = LEN_MAX;
    end
    return r;
  endfunction : len_clamp

  // command queue signals
  logic cmd_valid;
  logic cmd_pop;
  logic [CMD_W-1:0] cmd_data;
  logic [CMD_W-1:0] cmd_in;

  // engine state
  smwl_state_e state_r;
  smwl_state_e state_nxt;
  logic [15:0] div_cnt_r;
  logic [5:0] edge_cnt_r;
  logic [23:0] tx_sh_r;
  logic [23:0] rx_sh_r;
  logic mosi_r;
  logic sclk_r;
  logic cpha_r;
  logic [4:0] len_r;
  logic ss_level_r;
  logic busy_r;
  logic done_r;
  logic [7:0] rx_low_r;
  logic [7:0] rx_mid_r;
  logic [7:0] rx_high_r;

  // pin registers
  logic pin4_r;
  logic pin5_r;
  logic pin7_r;
  logic oe_r;

  // data in synchroniser; only the second stage is read
  logic miso_s1_r;
  logic miso_s2_r;

  // snapshot of the queued command; phase, length and transmit bytes are taken at the execute write
  assign cmd_in = {execute_control[EXE_SS_BIT],
                   execute_control[EXE_GO_BIT],
                   cfg_cpha,
                   len_clamp(transfer_length_field),
                   transmit_byte_high,
                   transmit_byte_mid,
                   transmit_byte_low};

  // writes queue whether or not loopback is on; four entries let select,
  // go and deselect be queued back to back
  smwl_fifo #(
    .WIDTH(CMD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_cmd_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(execute_wr),
    .in_ready(execute_ready),
    .in_data(cmd_in),
    .out_valid(cmd_valid),
    .out_ready(cmd_pop),
    .out_data(cmd_data)
  );

  // command decode; a command is taken only while the engine is idle
  assign cmd_pop = (state_r == ST_IDLE) & cmd_valid;
  wire cmd_ss = cmd_data[CMD_SS_POS];
  wire cmd_go = cmd_data[CMD_GO_POS];
  wire cmd_cpha = cmd_data[CMD_CPHA_POS];
  wire [4:0] cmd_len = cmd_data[CMD_LEN_POS +: LEN_W];
  wire [23:0] cmd_tx = cmd_data[23:0];
  wire start = cmd_pop & cmd_go;
  // left-align so the top programmed bit leaves first
  wire [23:0] tx_aligned = cmd_tx << (5'(MAX_BITS) - cmd_len);

  // half period divider, running only while a frame is on
  wire running = (state_r == ST_SHIFT) | (state_r == ST_TAIL);
  wire tick = running & (div_cnt_r == HALF_LAST);
  wire shift_tick = tick & (state_r == ST_SHIFT);
  // edges are numbered from zero; even numbers are leading edges
  wire is_lead = ~edge_cnt_r[0];
  // a frame has 2n edges, so the last one is number 2n-1
  wire [5:0] last_num = {len_r, 1'b0} - 6'h01;
  wire last_edge = edge_cnt_r == last_num;
  wire sample_now = shift_tick & (cpha_r ^ is_lead);
  wire drive_now = shift_tick & ~(cpha_r ^ is_lead);
  wire finish = tick & (state_r == ST_TAIL);
  // loopback takes the internal data out instead of the pin
  wire rx_bit = loopback_en ? mosi_r : miso_s2_r;

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start) begin
          state_nxt = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (shift_tick & last_edge) begin
          state_nxt = ST_TAIL;
        end
      end
      ST_TAIL: begin
        if (tick) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // half period divider
  always_ff @(posedge clk) begin
    if (rst | ~running | tick) begin
      div_cnt_r <= DIV_RST;
    end else begin
      div_cnt_r <= div_cnt_r + 16'h0001;
    end
  end

  // edge counter and internal serial clock; 2n toggles end at idle level,
  // and a restart at each go keeps a frame off any stale edge count
  always_ff @(posedge clk) begin
    if (rst | start) begin
      edge_cnt_r <= EDGE_RST;
      sclk_r <= 1'b0;
    end else if (shift_tick) begin
      edge_cnt_r <= edge_cnt_r + 6'h01;
      sclk_r <= ~sclk_r;
    end
  end

  // per transfer format, held for the whole frame
  always_ff @(posedge clk) begin
    if (rst) begin
      cpha_r <= 1'b0;
      len_r <= LEN_MIN;
    end else if (start) begin
      cpha_r <= cmd_cpha;
      len_r <= cmd_len;
    end
  end

  // transmit shifter; phase zero puts the first bit out before any edge,
  // while phase one waits for the leading edge to put it out
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_sh_r <= WORD_RST;
      mosi_r <= 1'b0;
    end else if (start & cmd_cpha) begin
      tx_sh_r <= tx_aligned;
    end else if (start) begin
      tx_sh_r <= {tx_aligned[22:0], 1'b0};
      mosi_r <= tx_aligned[23];
    end else if (drive_now) begin
      tx_sh_r <= {tx_sh_r[22:0], 1'b0};
      mosi_r <= tx_sh_r[23];
    end
  end

  // receive shifter fills from the bottom so bits end right-aligned
  always_ff @(posedge clk) begin
    if (rst | start) begin
      rx_sh_r <= WORD_RST;
    end else if (sample_now) begin
      rx_sh_r <= {rx_sh_r[22:0], rx_bit};
    end
  end

  // receive bytes update once, when the frame ends, so a host read
  // during a frame sees the previous word whole
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_low_r <= BYTE_RST;
      rx_mid_r <= BYTE_RST;
      rx_high_r <= BYTE_RST;
    end else if (finish) begin
      rx_low_r <= rx_sh_r[7:0];
      rx_mid_r <= rx_sh_r[15:8];
      rx_high_r <= rx_sh_r[23:16];
    end
  end

  // busy and done; start and finish never share a cycle. done stays up
  // until the next go so a slow poll still sees the frame end
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (start) begin
      busy_r <= 1'b1;
      done_r <= 1'b0;
    end else if (finish) begin
      busy_r <= 1'b0;
      done_r <= 1'b1;
    end
  end

  // select level follows every taken command, go or not; a deselect
  // queued behind a frame waits for it, so select never lifts mid frame
  always_ff @(posedge clk) begin
    if (rst) begin
      ss_level_r <= SS_LEVEL_RST;
    end else if (cmd_pop) begin
      ss_level_r <= cmd_ss;
    end
  end

  // data in crosses from the pin through two flops; their delay is what
  // sets the least half period
  always_ff @(posedge clk) begin
    if (rst) begin
      miso_s1_r <= 1'b0;
      miso_s2_r <= 1'b0;
    end else begin
      miso_s1_r <= port_pin_six_i;
      miso_s2_r <= miso_s1_r;
    end
  end

  // pin drive; frozen in loopback, which also latches the select level
  // that stood when loopback was entered. changing polarity while frozen
  // lands on the pin as a step once loopback ends.
  always_ff @(posedge clk) begin
    if (rst) begin
      pin4_r <= 1'b0;
      pin5_r <= 1'b0;
      pin7_r <= SS_LEVEL_RST;
    end else if (~loopback_en) begin
      pin4_r <= cfg_cpol ^ sclk_r;
      pin5_r <= mosi_r;
      pin7_r <= ss_level_r;
    end else begin
      pin4_r <= pin4_r;
      pin5_r <= pin5_r;
      pin7_r <= pin7_r;
    end
  end

  // pins are driven only when the master owns them
  always_ff @(posedge clk) begin
    if (rst) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= pin_config_first;
    end
  end

  // outputs straight from flops
  assign port_pin_four_o = pin4_r;
  assign port_pin_five_o = pin5_r;
  assign port_pin_seven_o = pin7_r;
  assign port_pin_four_oe = oe_r;
  assign port_pin_five_oe = oe_r;
  assign port_pin_seven_oe = oe_r;
  assign receive_byte_low = rx_low_r;
  assign receive_byte_mid = rx_mid_r;
  assign receive_byte_high = rx_high_r;
  assign xfer_busy = busy_r;
  assign xfer_done = done_r;
  assign ss_level = ss_level_r;

endmodule : smwl_spi_master

// ===== tb/smwl_props.sv
// checker: port timing of the spi master
// assumes execute values 0x01 and 0x02 only, set up outside frames
`timescale 1ns/1ps

module smwl_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin_config_first,
  input wire logic cfg_cpol,
  input wire logic [4:0] transfer_length_field,
  input wire logic execute_wr,
  input wire logic [7:0] execute_control,
  input wire logic loopback_en,
  input wire logic port_pin_four_o,
  input wire logic port_pin_four_oe,
  input wire logic port_pin_seven_o,
  input wire logic [7:0] receive_byte_low,
  input wire logic xfer_busy,
  input wire logic xfer_done,
  input wire logic ss_level
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  logic pin_r;
  logic busy_r;
  logic [5:0] tgl_r;
  logic [4:0] len;
  // zero means one bit, anything above 24 means 24
  assign len = transfer_length_field == 5'h00 ? 5'h01 :
    (transfer_length_field > 5'h18 ? 5'h18 : transfer_length_field);
  // clock pin toggles since the frame began, kept past the frame end
  always_ff @(posedge clk) begin
    pin_r <= port_pin_four_o;
    busy_r <= xfer_busy;
    tgl_r <= (xfer_busy && !busy_r) ? 6'h00 :
      tgl_r + {5'h00, port_pin_four_o != pin_r};
  end
  AST_PIN_ENABLE: assert property (
    $past(!rst) |-> port_pin_four_oe == $past(pin_config_first))
    else $error("pin enable not followed");
  AST_SELECT_PIN: assert property (
    $past(!rst) && $past(!loopback_en) && $past(!loopback_en, 2)
    |-> port_pin_seven_o == $past(ss_level))
    else $error("select pin off its level");
  AST_LOOP_STATIC: assert property (
    loopback_en && $past(loopback_en) && $past(loopback_en, 2)
    |-> $stable(port_pin_four_o) && $stable(port_pin_seven_o))
    else $error("pin moved in loopback");
  AST_EDGE_COUNT: assert property (
    $rose(xfer_done) |=> tgl_r == (loopback_en ? 6'h00 : {len, 1'b0}))
    else $error("clock edge count wrong");
  AST_DONE_CLEAR: assert property (
    xfer_busy |-> !xfer_done)
    else $error("done high in a frame");
  AST_DONE_SET: assert property (
    $fell(xfer_busy) |-> xfer_done)
    else $error("done missing at frame end");
  AST_RX_HOLD: assert property (
    xfer_busy && $past(xfer_busy) |-> $stable(receive_byte_low))
    else $error("receive byte moved in a frame");
  AST_IDLE_LEVEL: assert property (
    !xfer_busy && $past(!xfer_busy) && $past(!loopback_en) && $past(!rst)
    |-> port_pin_four_o == $past(cfg_cpol))
    else $error("idle clock level wrong");
  AST_DESELECT: assert property (
    execute_wr && execute_control == 8'h02 |-> ##[2:200] ss_level)
    else $error("deselect not taken");
endmodule : smwl_props

bind smwl_spi_master smwl_props u_props (.clk, .rst, .pin_config_first,
  .cfg_cpol, .transfer_length_field, .execute_wr, .execute_control,
  .loopback_en, .port_pin_four_o, .port_pin_four_oe, .port_pin_seven_o,
  .receive_byte_low, .xfer_busy, .xfer_done, .ss_level);

// ===== tb/smwl_slave_model.sv
// slave model: replies msb first and records what the master shifts out
// assumes select active low and a polarity that stays put in a frame
`timescale 1ns/1ps

module smwl_slave_model (
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ss_n,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [23:0] word,
  input wire logic [4:0] nbits,
  output logic miso,
  output logic [23:0] got,
  output logic [5:0] cnt
);
  logic [23:0] sh = 24'h000000;
  initial miso = 1'b0;
  // select falls: left align the reply, first bit out at once in phase 0
  always @(negedge ss_n) begin
    sh = word << (5'h18 - nbits);
    got = 24'h000000;
    cnt = 6'h00;
    if (!cpha) begin
      miso = sh[23];
      sh = sh << 1;
    end
  end
  // a released line must not keep showing the last bit
  always @(posedge ss_n) miso = ~miso;
  // sample on the edge the phase picks, shift out on the other
  always @(sclk) begin
    if (!ss_n && ((sclk != cpol) == !cpha)) begin
      got = {got[22:0], mosi};
      cnt = cnt + 6'h01;
    end else if (!ss_n) begin
      miso = sh[23];
      sh = sh << 1;
    end
  end
endmodule : smwl_slave_model

// ===== tb/testbench.sv
// testbench: corner and random frames against a slave model, then loopback
// assumes the master runs with a four cycle half period, an 800 ns clock
`timescale 1ns/1ps

module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pcf = 1'b1;
  logic cpol = 1'b0;
  logic cpha = 1'b0;
  logic lb = 1'b0;
  logic wr = 1'b0;
  logic [7:0] ctrl = 8'h00;
  logic [4:0] len = 5'h08;
  logic [4:0] n_eff = 5'h08;
  logic [23:0] tx = 24'h000000;
  logic [23:0] sw = 24'h000000;
  logic [4:0] lens [6] = '{5'h01, 5'h18, 5'h00, 5'h1f, 5'h02, 5'h17};
  logic [5:0] cnt;
  wire [23:0] rx;
  wire [23:0] got;
  wire rdy, sck, sck_oe, mo, mo_oe, mi, ss, ss_oe, busy, done, ssl;
  int n_mismatch = 0;
  int compares = 0;
  int seed = 32'hdf3f;
  always #50 clk = ~clk;
  smwl_spi_master #(.HALF_CYC(4)) uut (.clk(clk), .rst(rst),
    .pin_config_first(pcf), .cfg_cpol(cpol), .cfg_cpha(cpha),
    .transfer_length_field(len), .transmit_byte_low(tx[7:0]),
    .transmit_byte_mid(tx[15:8]), .transmit_byte_high(tx[23:16]),
    .execute_wr(wr), .execute_control(ctrl), .loopback_en(lb),
    .execute_ready(rdy), .port_pin_four_o(sck), .port_pin_four_oe(sck_oe),
    .port_pin_five_o(mo), .port_pin_five_oe(mo_oe), .port_pin_six_i(mi),
    .port_pin_seven_o(ss), .port_pin_seven_oe(ss_oe),
    .receive_byte_low(rx[7:0]), .receive_byte_mid(rx[15:8]),
    .receive_byte_high(rx[23:16]), .xfer_busy(busy), .xfer_done(done),
    .ss_level(ssl));
  smwl_slave_model slave (.sclk(sck), .mosi(mo), .ss_n(ss), .cpol(cpol),
    .cpha(cpha), .word(sw), .nbits(n_eff), .miso(mi), .got(got), .cnt(cnt));

  task automatic chk(input string what, input logic [23:0] seen,
      input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // zero asks for one bit, anything past 24 is cut to 24
  function automatic logic [4:0] eff_len(input logic [4:0] l);
    return l == 5'h00 ? 5'h01 : (l > 5'h18 ? 5'h18 : l);
  endfunction : eff_len

  function automatic logic [23:0] keep(input logic [23:0] w,
      input logic [4:0] n);
    return w & ((24'h000001 << n) - 24'h000001);
  endfunction : keep

  // ready is looked at away from the edge so the take is not a race
  task automatic exec(input logic [7:0] c);
    for (int i = 0; i < 50 && rdy !== 1'b1; i++) @(negedge clk);
    chk("queue room", {23'h0, rdy}, 24'h000001);
    @(posedge clk);
    ctrl <= c;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : exec

  task automatic frame(input logic [4:0] l, input logic p, input logic h,
      input logic loop, input logic pin_en);
    @(posedge clk);
    lb <= 1'b0;
    repeat (2) @(posedge clk);
    cpol <= p;
    cpha <= h;
    len <= l;
    pcf <= pin_en;
    n_eff <= eff_len(l);
    tx <= 24'($random(seed));
    sw <= 24'($random(seed));
    repeat (3) @(posedge clk);
    lb <= loop;
    repeat (3) @(posedge clk);
    exec(8'h01);
    repeat (4) @(posedge clk);
    for (int i = 0; i < 300 && done !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    chk("done flag", {23'h0, done}, 24'h000001);
    chk("receive word", rx, keep(loop ? tx : sw, n_eff));
    chk("select pin", {23'h0, ss}, {23'h0, loop});
    chk("pin enables", {21'h0, sck_oe, mo_oe, ss_oe}, {21'h0, {3{pcf}}});
    if (!loop) begin
      chk("slave word", got, keep(tx, n_eff));
      chk("slave bits", {18'h0, cnt}, {19'h0, n_eff});
    end
    exec(8'h02);
    repeat (6) @(negedge clk);
    chk("deselect", {22'h0, ss, ssl}, 24'h000003);
  endtask : frame

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  // corner lengths first, then random ones, all four modes, then loopback
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 14; i++) begin
      frame(i < 6 ? lens[i] : 5'($random(seed)), i[0], i[1], i >= 12, i != 5);
      $display("test %0d done", i);
    end
    give_verdict();
  end

  // watchdog far beyond fourteen frames at the short half period
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
endmodule : testbench
